// ==== logic/nand_host.sv ====
// host-side controller driving an asynchronous multiplexed nand flash
// What this block does
// - address goes out as three write-strobe cycles
// - each read-strobe pulse fetches the next byte
// - page program limit for the last programmed page: main twice, spare thrice
// - no program or erase to marked blocks
// - track blocks gone bad during use
// - flag more than ten bad blocks
`timescale 1ns/100ps
`include "nand_host_defines.svh"

module nand_host #(
	parameter int PROG_TMO_CYC = `PROG_BUSY_US * `CLK_MHZ,
	parameter int ERASE_TMO_CYC = `ERASE_BUSY_US * `CLK_MHZ
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	output logic req_ready,
	input nand_host_pkg::req_s req,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [7:0] rd_data,
	output nand_host_pkg::status_s status,
	input wire logic write_enable,
	input wire logic spare_only,
	output nand_host_pkg::pins_s pins,
	input wire logic [7:0] io_in,
	input wire logic rb_n
);
	import nand_host_pkg::*;

	logic [1:0] rst_sync_reg;
	logic rst_n_i;
	host_state_s s_reg;
	host_state_s s_next;
	logic bad_tbl [`BLOCK_TOTAL];
	logic [9:0] blk;
	logic same_row;
	logic prog_ok;
	logic erase_ok;
	logic accept;
	logic mark_new;
	logic pop;
	logic push;
	logic [16:0] limit;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n_i = rst_sync_reg[1];

	assign blk = s_reg.row[13:4];
	assign same_row = s_reg.row == s_reg.last_row;
	assign prog_ok = !bad_tbl[blk] && (s_reg.spare_ptr ?
		!(same_row && s_reg.spare_cnt >= `NOP_SPARE) :
		!(same_row && s_reg.main_cnt >= `NOP_MAIN));
	assign erase_ok = !bad_tbl[blk];
	assign req_ready = s_reg.st == ST_IDLE &&
		!(req.op == OP_READ && s_reg.buf_cnt == 2'h2);
	assign accept = req_valid && req_ready;
	assign mark_new = accept && req.op == OP_MARK_BAD && blk != 10'h000 &&
		!bad_tbl[blk];
	assign pop = rd_valid && rd_ready;
	assign push = s_reg.st == ST_RD_LOW;
	assign rd_valid = s_reg.buf_cnt != 2'h0;
	assign rd_data = s_reg.buf0;
	assign pins = s_reg.pins;
	assign status = '{refused: s_reg.refused, timed_out: s_reg.timed_out,
		too_many_bad: s_reg.bad_cnt > `BAD_LIMIT,
		done: s_reg.done};

	always_comb begin
		unique case (s_reg.wsel)
			WAIT_PROG: limit = 17'(PROG_TMO_CYC - 1);
			WAIT_ERASE: limit = 17'(ERASE_TMO_CYC - 1);
			default: limit = 17'(`READ_BUSY_CYC - 1);
		endcase
	end

	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.pins.wp_n = write_enable;
		s_next.pins.spare_sel = spare_only;
		// two-entry read buffer, head in buf0
		if (pop) begin
			s_next.buf0 = s_reg.buf1;
		end
		if (push) begin
			if (s_reg.buf_cnt == 2'h0 || (s_reg.buf_cnt == 2'h1 && pop)) begin
				s_next.buf0 = io_in;
			end else begin
				s_next.buf1 = io_in;
			end
		end
		s_next.buf_cnt = 2'(s_reg.buf_cnt + {1'b0, push} - {1'b0, pop});
		unique case (s_reg.st)
			ST_IDLE: begin
				s_next.pins.ce_n = 1'b1;
				s_next.pins.cle = 1'b0;
				s_next.pins.ale = 1'b0;
				s_next.pins.io_oe = 1'b0;
				s_next.pins.we_n = 1'b1;
				s_next.pins.read_strobe_n = 1'b1;
				if (accept) begin
					s_next.refused = 1'b0;
					s_next.timed_out = 1'b0;
					s_next.cmd_confirm = 1'b0;
					unique case (req.op)
						OP_CMD: begin
							s_next.addr_idx = 2'h0;
							s_next.st = ST_WR_LOW;
							if (req.data == `CMD_READ_SPARE) begin
								s_next.spare_ptr = 1'b1;
							end else if (req.data == `CMD_READ_MAIN0 ||
								req.data == `CMD_READ_MAIN1) begin
								s_next.spare_ptr = 1'b0;
							end
							if (req.data == `CMD_PROG_CONFIRM) begin
								s_next.wsel = WAIT_PROG;
								s_next.cmd_confirm = 1'b1;
								if (!prog_ok) begin
									s_next.st = ST_IDLE;
									s_next.refused = 1'b1;
									s_next.done = 1'b1;
								end else if (same_row) begin
									if (s_reg.spare_ptr) begin
										s_next.spare_cnt = 2'(s_reg.spare_cnt + 2'h1);
									end else begin
										s_next.main_cnt = 2'(s_reg.main_cnt + 2'h1);
									end
								end else begin
									s_next.last_row = s_reg.row;
									s_next.main_cnt = {1'b0, !s_reg.spare_ptr};
									s_next.spare_cnt = {1'b0, s_reg.spare_ptr};
								end
							end
							if (req.data == `CMD_ERASE_CONFIRM) begin
								s_next.wsel = WAIT_ERASE;
								s_next.cmd_confirm = 1'b1;
								if (!erase_ok) begin
									s_next.st = ST_IDLE;
									s_next.refused = 1'b1;
									s_next.done = 1'b1;
								end else if (s_reg.last_row[13:4] == blk) begin
									s_next.main_cnt = 2'h0;
									s_next.spare_cnt = 2'h0;
								end
							end
							s_next.pins.cle = 1'b1;
						end
						OP_ADDR: begin
							s_next.st = ST_WR_LOW;
							s_next.pins.ale = 1'b1;
							s_next.addr_idx = s_reg.addr_idx == 2'h2 ? 2'h0 :
								2'(s_reg.addr_idx + 2'h1);
							if (s_reg.addr_idx == 2'h1) begin
								s_next.row[7:0] = req.data;
							end else if (s_reg.addr_idx == 2'h2) begin
								s_next.row[13:8] = req.data[5:0];
							end
						end
						OP_WRITE: begin
							s_next.st = ST_WR_LOW;
						end
						OP_READ: begin
							s_next.st = ST_RD_LOW;
							s_next.pins.ce_n = 1'b0;
							s_next.pins.read_strobe_n = 1'b0;
						end
						OP_WAIT: begin
							s_next.st = ST_BUSY_DLY;
							s_next.wsel = WAIT_READ;
							s_next.tmo = 17'h0_0000;
							s_next.pins.ce_n = 1'b0;
						end
						default: begin
							if (mark_new) begin
								s_next.bad_cnt = 11'(s_reg.bad_cnt + 11'h001);
							end
							s_next.done = 1'b1;
						end
					endcase
					if (s_next.st == ST_WR_LOW) begin
						s_next.pins.ce_n = 1'b0;
						s_next.pins.we_n = 1'b0;
						s_next.pins.io_oe = 1'b1;
						s_next.pins.io_out = req.data;
					end
				end
			end
			ST_WR_LOW: begin
				s_next.pins.we_n = 1'b1;
				s_next.st = ST_WR_HOLD;
			end
			ST_WR_HOLD: begin
				s_next.pins.io_oe = 1'b0;
				s_next.tmo = 17'h0_0000;
				if (s_reg.cmd_confirm) begin
					s_next.st = ST_BUSY_DLY;
				end else begin
					s_next.st = ST_IDLE;
					s_next.done = 1'b1;
				end
			end
			ST_RD_LOW: begin
				s_next.pins.read_strobe_n = 1'b1;
				s_next.st = ST_IDLE;
				s_next.done = 1'b1;
			end
			ST_BUSY_DLY: begin
				// busy may take a while to fall after the strobe
				s_next.tmo = 17'(s_reg.tmo + 17'h0_0001);
				if (s_reg.tmo >= 17'(`WB_CYC - 1)) begin
					s_next.tmo = 17'h0_0000;
					s_next.st = ST_BUSY_POLL;
				end
			end
			default: begin
				if (rb_n) begin
					s_next.st = ST_IDLE;
					s_next.done = 1'b1;
				end else if (s_reg.tmo >= limit) begin
					s_next.st = ST_IDLE;
					s_next.timed_out = 1'b1;
					s_next.done = 1'b1;
				end else begin
					s_next.tmo = 17'(s_reg.tmo + 17'h0_0001);
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_reg <= '0;
			s_reg.st <= ST_IDLE;
			s_reg.pins.ce_n <= 1'b1;
			s_reg.pins.we_n <= 1'b1;
			s_reg.pins.read_strobe_n <= 1'b1;
			s_reg.wsel <= WAIT_READ;
		end else begin
			s_reg <= s_next;
		end
	end

	// table cleared at reset so a fresh part starts all-valid
	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < `BLOCK_TOTAL; i++) begin
				bad_tbl[i] <= 1'b0;
			end
		end else if (mark_new) begin
			bad_tbl[blk] <= 1'b1;
		end
	end

	a_cmd_latch: assert property (@(posedge clk) disable iff (!rst_n_i)
		(!pins.we_n && pins.cle) |=> (pins.we_n && pins.cle && !pins.ale
		&& pins.io_oe && $stable(pins.io_out)))
		else $error("command byte not held across strobe rise");
	a_addr_pins: assert property (@(posedge clk) disable iff (!rst_n_i)
		(!pins.we_n && pins.ale) |-> (!pins.cle && !pins.ce_n
		&& pins.read_strobe_n))
		else $error("address cycle pins wrong");
	a_read_pins: assert property (@(posedge clk) disable iff (!rst_n_i)
		!pins.read_strobe_n |-> (!pins.cle && !pins.ale && pins.we_n
		&& !pins.ce_n && !pins.io_oe) ##1 pins.read_strobe_n)
		else $error("read strobe pins wrong");
	a_spare_follow: assert property (@(posedge clk) disable iff (!rst_n_i)
		$past(rst_n_i) |-> pins.spare_sel == $past(spare_only))
		else $error("spare select does not follow request");
	a_wp_follow: assert property (@(posedge clk) disable iff (!rst_n_i)
		$past(rst_n_i) |-> pins.wp_n == $past(write_enable))
		else $error("write protect does not follow enable");
	a_block0_kept: assert property (@(posedge clk) disable iff (!rst_n_i)
		!bad_tbl[0])
		else $error("block zero marked bad");
	a_no_bad_prog: assert property (@(posedge clk) disable iff (!rst_n_i)
		(s_reg.st == ST_BUSY_DLY && s_reg.wsel != WAIT_READ) |-> !bad_tbl[blk])
		else $error("program or erase sent to a bad block");
	a_nop_limit: assert property (@(posedge clk) disable iff (!rst_n_i)
		s_reg.main_cnt <= `NOP_MAIN && s_reg.spare_cnt <= `NOP_SPARE)
		else $error("partial program count exceeded");
	a_bad_flag: assert property (@(posedge clk) disable iff (!rst_n_i)
		mark_new && s_reg.bad_cnt == `BAD_LIMIT |=> status.too_many_bad)
		else $error("bad block overflow not flagged");
	a_ce_busy: assert property (@(posedge clk) disable iff (!rst_n_i)
		(s_reg.st == ST_BUSY_POLL && !rb_n && s_reg.tmo < limit)
		|=> (!pins.ce_n && s_reg.st == ST_BUSY_POLL))
		else $error("busy wait ended early");
endmodule

// ==== common/nand_host_defines.svh ====
// timing counts, command codes and limits for the nand host controller
`ifndef NAND_HOST_DEFINES_SVH
`define NAND_HOST_DEFINES_SVH

`define CLK_MHZ 20
`define WB_TIME_NS 100
`define WB_CYC ((`WB_TIME_NS * `CLK_MHZ) / 1000)
`define READ_BUSY_US 10
`define READ_BUSY_CYC (`READ_BUSY_US * `CLK_MHZ)
`define PROG_BUSY_US 500
`define ERASE_BUSY_US 4000

`define CMD_READ_MAIN0 8'h00
`define CMD_READ_MAIN1 8'h01
`define CMD_READ_SPARE 8'h50
`define CMD_PROG_CONFIRM 8'h10
`define CMD_ERASE_CONFIRM 8'hD0

`define NOP_MAIN 2'h2
`define NOP_SPARE 2'h3
`define BLOCK_TOTAL 1024
`define VALID_BLOCK_MIN 1014
`define BAD_LIMIT 11'h00A

`endif

// ==== common/nand_host_pkg.sv ====
// types shared by the nand host controller and its users
package nand_host_pkg;

	typedef enum logic [2:0] {
		OP_CMD = 3'h0,
		OP_ADDR = 3'h1,
		OP_WRITE = 3'h2,
		OP_READ = 3'h3,
		OP_WAIT = 3'h4,
		OP_MARK_BAD = 3'h5
	} op_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WR_LOW = 3'h1,
		ST_WR_HOLD = 3'h2,
		ST_RD_LOW = 3'h3,
		ST_BUSY_DLY = 3'h4,
		ST_BUSY_POLL = 3'h5
	} state_e;

	typedef enum logic [1:0] {
		WAIT_READ = 2'h0,
		WAIT_PROG = 2'h1,
		WAIT_ERASE = 2'h2
	} wait_e;

	typedef struct packed {
		op_e op;
		logic [7:0] data;
	} req_s;

	typedef struct packed {
		logic cle;
		logic ale;
		logic ce_n;
		logic we_n;
		logic read_strobe_n;
		logic wp_n;
		logic spare_sel;
		logic io_oe;
		logic [7:0] io_out;
	} pins_s;

	typedef struct packed {
		logic refused;
		logic timed_out;
		logic too_many_bad;
		logic done;
	} status_s;

	typedef struct packed {
		state_e st;
		pins_s pins;
		logic cmd_confirm;
		logic [1:0] addr_idx;
		logic [13:0] row;
		logic [13:0] last_row;
		logic [1:0] main_cnt;
		logic [1:0] spare_cnt;
		logic spare_ptr;
		wait_e wsel;
		logic [16:0] tmo;
		logic [10:0] bad_cnt;
		logic [7:0] buf0;
		logic [7:0] buf1;
		logic [1:0] buf_cnt;
		logic refused;
		logic timed_out;
		logic done;
	} host_state_s;

endpackage

// ==== dv/nand_dev_model.sv ====
// behavioural flash device answering the host controller pins
`timescale 1ns/100ps

module nand_dev_model (
	input wire logic clk,
	input nand_host_pkg::pins_s pins,
	input wire logic [7:0] busy_len,
	output logic [7:0] io_in,
	output logic rb_n
);
	import nand_host_pkg::*;

	logic [7:0] cmd_reg = 8'h00;
	logic [7:0] addr_q [3];
	logic [1:0] aidx = 2'h0;
	logic [9:0] col = 10'h000;
	logic [7:0] busy_cnt = 8'h00;
	logic [7:0] last = 8'h00;
	pins_s prev = '1;

	// released bus shows the inverse, so a late sample cannot pass
	assign io_in = (!pins.ce_n && !pins.read_strobe_n) ?
		({col[9:8], col[5:0]} ^ 8'h3c) : ~last;
	assign rb_n = (busy_cnt == 8'h00);

	always @(posedge clk) begin
		prev <= pins;
		if (busy_cnt != 8'h00) begin
			busy_cnt <= busy_cnt - 8'h01;
		end
		if (!prev.ce_n && !prev.we_n && pins.we_n) begin
			if (prev.cle) begin
				cmd_reg <= prev.io_out;
				aidx <= 2'h0;
				// program and erase only start with protection lifted
				if ((prev.io_out == 8'h10 || prev.io_out == 8'hd0) &&
						prev.wp_n) begin
					busy_cnt <= busy_len;
				end
			end else if (prev.ale) begin
				addr_q[aidx] <= prev.io_out;
				aidx <= (aidx == 2'h2) ? 2'h0 : aidx + 2'h1;
				if (aidx == 2'h0) begin
					col <= {1'b0, cmd_reg == 8'h01, prev.io_out};
				end
				// page fetch into the register after the last read address
				if (aidx == 2'h2 && (cmd_reg == 8'h00 || cmd_reg == 8'h01 ||
						cmd_reg == 8'h50)) begin
					busy_cnt <= busy_len;
				end
			end
		end
		if (!prev.ce_n && !prev.read_strobe_n && pins.read_strobe_n) begin
			last <= {col[9:8], col[5:0]} ^ 8'h3c;
			// spare columns skipped while spare_sel is high
			col <= (pins.spare_sel && col == 10'h1ff) ? 10'h000 :
				col + 10'h001;
		end
	end
endmodule

// ==== dv/testbench.sv ====
// randomised self-checking bench for the nand host controller
`timescale 1ns/100ps

module testbench;
	import nand_host_pkg::*;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	logic req_ready;
	req_s req = '0;
	logic rd_valid;
	logic rd_ready = 1'b0;
	logic [7:0] rd_data;
	status_s status;
	logic write_enable = 1'b1;
	logic spare_only = 1'b0;
	pins_s pins;
	logic [7:0] io_in;
	logic rb_n;
	logic [7:0] busy_len = 8'h05;
	int errors = 0;
	int samples_checked = 0;
	logic [31:0] seed = 32'ha358;

	nand_host #(.PROG_TMO_CYC(20), .ERASE_TMO_CYC(40)) uut (.clk(clk),
		.rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
		.req(req), .rd_valid(rd_valid), .rd_ready(rd_ready),
		.rd_data(rd_data), .status(status), .write_enable(write_enable),
		.spare_only(spare_only), .pins(pins), .io_in(io_in), .rb_n(rb_n));

	nand_dev_model dev (.clk(clk), .pins(pins), .busy_len(busy_len),
		.io_in(io_in), .rb_n(rb_n));

	initial begin
		forever #25 clk = ~clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	function automatic logic [7:0] exp_byte(input logic [9:0] c);
		return {c[9:8], c[5:0]} ^ 8'h3c;
	endfunction

	task automatic check(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			errors++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic run(input op_e o, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{op: o, data: d};
		@(negedge clk);
		while (req_ready !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		req_valid <= 1'b0;
		do begin
			@(negedge clk);
			n++;
		end while (status.done !== 1'b1 && n < 400);
		if (n >= 400) begin
			check(1'b0, "request hung");
			test_done();
		end
	endtask

	task automatic setup(input logic [7:0] c, input logic [7:0] a0,
			input logic [7:0] a1, input logic [7:0] a2);
		run(OP_CMD, c);
		run(OP_ADDR, a0);
		run(OP_ADDR, a1);
		run(OP_ADDR, a2);
	endtask

	task automatic prog(input logic [7:0] rlo, input logic [7:0] rhi);
		seed = xs(seed);
		setup(8'h80, seed[7:0], rlo, rhi);
		run(OP_WRITE, seed[15:8]);
		run(OP_CMD, 8'h10);
	endtask

	task automatic erase(input logic [7:0] rlo, input logic [7:0] rhi);
		setup(8'h60, 8'h00, rlo, rhi);
		run(OP_CMD, 8'hd0);
	endtask

	task automatic pop(input logic [7:0] e);
		@(negedge clk);
		check(rd_valid === 1'b1 && rd_data === e, "read byte");
		@(posedge clk);
		rd_ready <= 1'b1;
		@(posedge clk);
		rd_ready <= 1'b0;
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		while (rb_n !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		check(rb_n === 1'b1, "device stuck busy");
		if (rb_n !== 1'b1) begin
			test_done();
		end
	endtask

	initial begin
		int k;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		seed = xs(seed);
		setup(8'h00, seed[7:0], seed[15:8], {2'b00, seed[21:16]});
		check(dev.cmd_reg === 8'h00, "command byte");
		check(dev.addr_q[0] === seed[7:0] && dev.addr_q[1] === seed[15:8]
			&& dev.addr_q[2] === {2'b00, seed[21:16]}, "address");
		$display("address test ended");
		// reads pile up behind a stalled consumer
		for (k = 0; k < 2; k++) begin
			@(posedge clk);
			spare_only <= k[0];
			setup(8'h01, 8'hfe, 8'h00, 8'h00);
			run(OP_WAIT, 8'h00);
			check(status.timed_out === 1'b0 && rb_n === 1'b1, "fetch");
			run(OP_READ, 8'h00);
			run(OP_READ, 8'h00);
			@(negedge clk);
			check(req_ready === 1'b0 && pins.spare_sel === k[0], "full");
			pop(exp_byte(10'h1fe));
			pop(exp_byte(10'h1ff));
			run(OP_READ, 8'h00);
			pop(exp_byte(k[0] ? 10'h000 : 10'h200));
		end
		spare_only <= 1'b0;
		$display("read test ended");
		for (k = 0; k < 3; k++) begin
			prog(8'h25, 8'h01);
			check(status.refused === (k == 2), "page program count");
		end
		erase(8'h25, 8'h01);
		check(status.refused === 1'b0 && rb_n === 1'b1, "erase");
		prog(8'h25, 8'h01);
		check(status.refused === 1'b0, "count after erase");
		run(OP_MARK_BAD, 8'h00);
		prog(8'h25, 8'h01);
		check(status.refused === 1'b1 && dev.cmd_reg === 8'h80, "bad");
		erase(8'h25, 8'h01);
		check(status.refused === 1'b1, "erase of bad block");
		$display("program test ended");
		setup(8'h00, 8'h00, 8'h00, 8'h00);
		run(OP_MARK_BAD, 8'h00);
		prog(8'h00, 8'h00);
		check(status.refused === 1'b0, "block zero");
		for (k = 1; k < 11; k++) begin
			check(status.too_many_bad === 1'b0, "bad count early");
			setup(8'h00, 8'h00, {k[3:0], 4'h0}, 8'h00);
			run(OP_MARK_BAD, 8'h00);
		end
		check(status.too_many_bad === 1'b1, "bad count limit");
		$display("bad block test ended");
		busy_len <= 8'd60;
		prog(8'hd0, 8'h00);
		check(status.timed_out === 1'b1, "program timeout");
		wait_ready();
		erase(8'he0, 8'h00);
		check(status.timed_out === 1'b1, "erase timeout");
		wait_ready();
		@(posedge clk);
		write_enable <= 1'b0;
		repeat (3) @(posedge clk);
		check(pins.wp_n === 1'b0, "write protect");
		prog(8'hd0, 8'h00);
		check(status.timed_out === 1'b0 && dev.busy_cnt === 8'h00,
			"protected program");
		$display("timeout test ended");
		test_done();
	end
endmodule
